// ===== hdl/hcio_top.sv
/*
  Command interpreter that links the arithmetic unit to the supervisory
  processor over the shared command bus. Assumes bus lines synchronous to
  CLK and a host that holds command-present until it has seen an answer.
*/

// Functional notes
// - Interrupt output comes straight from its own flip-flop, set by microinstruction bit.
// - Interrupt bit lets instruction finish, then sets flag and stops unit clocks.
// - Unit stays halted with interrupt raised; any own command clears the flag.
// - Bus data is driven only while answering a host command.
// - Thirteen command lines watched: eight address, one command-present, four type bits.
// - Command taken only with command-present high and own address matching.
// - One 16-bit status word, readable whether running or stopped.
// - Control-type command interprets data bits as control code and acts.
// - Data-type command writes or reads one 16-bit scratch word.
// - Scratch address increments after transfer only when continue bit is one.
// - The CC_CLR_WADDR control command clears the scratch address to zero.
// - Status request drives status on data lines and raises Acknowledge.
// - While running, any command other than status request or stop gets Reject, not executed.
// - Two 3-bit buffer selects, host-written only, prefix channel addresses.
// - Start clears control-store address to zero and resumes sequencer.
// - Interrupt field value 0 leaves request unchanged, value 1 raises it.
// - Host-commanded jump to zero is unconditional.
module hcio_top
  import hcio_pkg::*;
(
  input wire logic CLK, // System clock, 20 MHz.
  input wire logic RST_N, // Asynchronous reset, active low.
  input wire logic CE, // Clock enable; low freezes all state.
  input wire hcio_pkg::hcio_cmd_t CMD, // Command lines of the shared bus.
  input wire logic [hcio_pkg::DATA_W-1:0] BUS_DATA_IN, // Data lines as seen on the bus.
  output hcio_pkg::hcio_rsp_t RSP, // Answer onto the shared bus.
  output logic INTERRUPT, // Interrupt line to the host.
  input wire logic UI_VALID, // A microinstruction completes this cycle.
  input wire logic UI_INT_REQ, // Interrupt field of that microinstruction.
  input wire logic [hcio_pkg::CSADDR_W-1:0] SEQ_NEXT_ADDR, // Sequencer's chosen next address.
  output logic [hcio_pkg::CSADDR_W-1:0] CS_ADDR, // Control store address register.
  output logic UNIT_CLK_EN, // Clock enable for arith, address and sequencer sections.
  input wire logic [hcio_pkg::CHADDR_W-1:0] CHA_ADDR, // Channel A address register.
  input wire logic [hcio_pkg::CHADDR_W-1:0] CHB_ADDR, // Channel B address register.
  output logic [hcio_pkg::BUFADDR_W-1:0] BUF_ADDR_A, // Full buffer address, channel A.
  output logic [hcio_pkg::BUFADDR_W-1:0] BUF_ADDR_B, // Full buffer address, channel B.
  output logic [hcio_pkg::WADDR_W-1:0] WADDR, // Scratch store address register.
  output logic [hcio_pkg::DATA_W-1:0] STATUS // Status word.
);
  import hcio_pkg::*;

  hcio_hs_t hs, next_hs;
  logic running, next_running;
  logic int_flag, next_int_flag;
  logic [WADDR_W-1:0] waddr, next_waddr;
  logic [BUFSEL_W-1:0] bufsel_a, next_bufsel_a;
  logic [BUFSEL_W-1:0] bufsel_b, next_bufsel_b;
  logic [CSADDR_W-1:0] cs_addr, next_cs_addr;
  logic ack, next_ack;
  logic reject, next_reject;
  logic drive, next_drive;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic ws_we;
  logic [DATA_W-1:0] ws_rdata;
  logic hit;
  logic [7:0] code;

  // Own address decode; the command is acted on once, on its first cycle.
  assign hit = CMD.present && (CMD.addr == DEV_ADDR);
  assign code = BUS_DATA_IN[7:0];

  // Status word collects run, interrupt, scratch address and buffer selects.
  always_comb begin
    STATUS = '0;
    STATUS[ST_RUN] = running;
    STATUS[ST_INT] = int_flag;
    STATUS[ST_WADDR_LSB +: WADDR_W] = waddr;
    STATUS[ST_BUFA_LSB +: BUFSEL_W] = bufsel_a;
    STATUS[ST_BUFB_LSB +: BUFSEL_W] = bufsel_b;
  end

  hcio_wstore u_wstore (
    .CLK(CLK),
    .CE(CE),
    .we(ws_we),
    .addr(waddr),
    .wdata(BUS_DATA_IN),
    .rdata(ws_rdata)
  );

  // Command interpreter and unit run control. An interrupt halt waits for the
  // completing instruction so its results are kept intact.
  always_comb begin
    next_hs = hs;
    next_running = running;
    next_int_flag = int_flag;
    next_waddr = waddr;
    next_bufsel_a = bufsel_a;
    next_bufsel_b = bufsel_b;
    next_cs_addr = cs_addr;
    next_ack = ack;
    next_reject = reject;
    next_drive = drive;
    next_rdata = rdata;
    ws_we = 1'b0;
    // Sequencer advances only while the unit clocks run.
    if (running && UI_VALID) begin
      next_cs_addr = SEQ_NEXT_ADDR;
      if (UI_INT_REQ) begin
        next_int_flag = 1'b1;
        next_running = 1'b0;
      end
    end
    unique case (hs)
      HS_IDLE: begin
        if (hit) begin
          next_hs = HS_BUSY;
          // A running unit keeps a halt request raised in this same cycle, so
          // the set wins; only a stopped unit has a flag for the command to clear.
          if (!running) begin
            next_int_flag = 1'b0;
          end
          if (CMD.is_ctrl && CMD.is_input) begin
            // Status may be read even while running.
            next_rdata = STATUS;
            next_drive = 1'b1;
            next_ack = 1'b1;
          end else if (running && !(CMD.is_ctrl && code == CC_STOP)) begin
            next_reject = 1'b1;
          end else if (CMD.is_ctrl) begin
            next_ack = 1'b1;
            unique case (code)
              CC_START: begin
                next_cs_addr = CS_START_ADDR;
                next_running = 1'b1;
              end
              CC_STOP: next_running = 1'b0;
              CC_CLR_WADDR: next_waddr = WADDR_RST;
              CC_BUFSEL: begin
                next_bufsel_a = BUS_DATA_IN[BUFSEL_A_LSB +: BUFSEL_W];
                next_bufsel_b = BUS_DATA_IN[BUFSEL_B_LSB +: BUFSEL_W];
              end
              default: next_ack = 1'b1;
            endcase
          end else if (CMD.is_data) begin
            next_ack = 1'b1;
            if (CMD.is_input) begin
              next_rdata = ws_rdata;
              next_drive = 1'b1;
            end else begin
              ws_we = 1'b1;
            end
            if (CMD.cont) begin
              next_waddr = waddr + 4'h1;
            end
          end else begin
            next_ack = 1'b1;
          end
        end
      end
      HS_BUSY: begin
        // Answers hold until the host withdraws command-present.
        if (!CMD.present) begin
          next_hs = HS_IDLE;
          next_ack = 1'b0;
          next_reject = 1'b0;
          next_drive = 1'b0;
        end
      end
    endcase
  end

  // State registers; CE low holds everything.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hs <= HS_IDLE;
      running <= 1'b0;
      int_flag <= 1'b0;
      waddr <= WADDR_RST;
      bufsel_a <= BUFSEL_RST;
      bufsel_b <= BUFSEL_RST;
      cs_addr <= CS_START_ADDR;
      ack <= 1'b0;
      reject <= 1'b0;
      drive <= 1'b0;
      rdata <= '0;
    end else if (CE) begin
      hs <= next_hs;
      running <= next_running;
      int_flag <= next_int_flag;
      waddr <= next_waddr;
      bufsel_a <= next_bufsel_a;
      bufsel_b <= next_bufsel_b;
      cs_addr <= next_cs_addr;
      ack <= next_ack;
      reject <= next_reject;
      drive <= next_drive;
      rdata <= next_rdata;
    end
  end

  // Bus answer and interrupt come straight from flip-flops; the data enable is active low.
  assign RSP.ack = ack;
  assign RSP.reject = reject;
  assign RSP.data = rdata;
  assign RSP.data_oe_n = !drive;
  assign INTERRUPT = int_flag;
  assign UNIT_CLK_EN = running && CE;
  assign CS_ADDR = cs_addr;
  assign WADDR = waddr;
  assign BUF_ADDR_A = {bufsel_a, CHA_ADDR};
  assign BUF_ADDR_B = {bufsel_b, CHB_ADDR};

  // Assertions.
  int_sets_halt_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && running && UI_VALID && UI_INT_REQ) |=> (INTERRUPT && !UNIT_CLK_EN))
    else $error("interrupt request did not halt the unit");

  int_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (INTERRUPT && !(CE && hs == HS_IDLE && hit)) |=> INTERRUPT)
    else $error("interrupt dropped without a command");

  int_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && hs == HS_IDLE && hit && !running) |=> !INTERRUPT)
    else $error("own command did not clear interrupt");

  bus_drive_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !RSP.data_oe_n |-> (hs == HS_BUSY))
    else $error("bus driven without a command");

  foreign_ignored_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && hs == HS_IDLE && !hit) |=> (!RSP.ack && !RSP.reject))
    else $error("answered a command not addressed here");

  status_ack_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && hs == HS_IDLE && hit && CMD.is_ctrl && CMD.is_input)
      |=> (RSP.ack && !RSP.data_oe_n && RSP.data == $past(STATUS)))
    else $error("status request not answered");

  busy_reject_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && hs == HS_IDLE && hit && running && !CMD.is_ctrl && CMD.is_data)
      |=> (RSP.reject && !RSP.ack && WADDR == $past(WADDR)))
    else $error("busy unit accepted a data command");

  cont_incr_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && hs == HS_IDLE && hit && !running && CMD.is_data && !CMD.is_ctrl)
      |=> (WADDR == $past(WADDR) + ($past(CMD.cont) ? 4'h1 : 4'h0)))
    else $error("scratch address step wrong");

  start_zero_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && hs == HS_IDLE && hit && !running && CMD.is_ctrl && !CMD.is_input
      && code == CC_START) |=> (CS_ADDR == CS_START_ADDR && UNIT_CLK_EN || !CE))
    else $error("start did not restart at zero");

  answer_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (RSP.ack && CMD.present) |=> RSP.ack)
    else $error("acknowledge dropped early");

  ctrl_ack_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && hs == HS_IDLE && hit && !running && CMD.is_ctrl && !CMD.is_input)
      |=> (RSP.ack && !RSP.reject && RSP.data_oe_n))
    else $error("control command not acknowledged");

  data_write_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && hs == HS_IDLE && hit && !running && !CMD.is_ctrl && CMD.is_data && !CMD.is_input)
      |=> (RSP.ack && !RSP.reject && RSP.data_oe_n))
    else $error("data write not acknowledged");

  data_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && hs == HS_IDLE && hit && !running && !CMD.is_ctrl && CMD.is_data && CMD.is_input)
      |=> (RSP.ack && !RSP.data_oe_n && RSP.data == $past(ws_rdata)))
    else $error("data read not answered with the stored word");

  clear_waddr_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && hs == HS_IDLE && hit && !running && CMD.is_ctrl && !CMD.is_input
      && code == CC_CLR_WADDR) |=> (WADDR == WADDR_RST))
    else $error("scratch address not cleared");

  bufsel_load_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && hs == HS_IDLE && hit && !running && CMD.is_ctrl && !CMD.is_input
      && code == CC_BUFSEL) |=> (bufsel_a == 3'($past(BUS_DATA_IN) >> BUFSEL_A_LSB)
      && bufsel_b == 3'($past(BUS_DATA_IN) >> BUFSEL_B_LSB)))
    else $error("buffer selects not loaded");

  bufsel_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !(CE && hs == HS_IDLE && hit && !running && CMD.is_ctrl && !CMD.is_input
      && code == CC_BUFSEL) |=> ($stable(bufsel_a) && $stable(bufsel_b)))
    else $error("buffer selects changed without a command");

  int_low_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && running && UI_VALID && !UI_INT_REQ && !INTERRUPT) |=> !INTERRUPT)
    else $error("interrupt raised by a clear interrupt field");

  waddr_wrap_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (CE && hs == HS_IDLE && hit && !running && !CMD.is_ctrl && CMD.is_data && CMD.cont
      && WADDR == 4'hF) |=> (WADDR == 4'h0))
    else $error("scratch address did not wrap to zero");

  reject_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (RSP.reject && CMD.present) |=> RSP.reject)
    else $error("reject dropped early");

  halt_stays_a: assert property (@(posedge CLK) disable iff (!RST_N)
    INTERRUPT |-> !UNIT_CLK_EN)
    else $error("unit clocks run while interrupted");

endmodule : hcio_top

// ===== hdl/hcio_pkg.sv
/*
  Shared constants and carrier types for the host command I/O control block.
  Assumes one synchronous system clock and a command bus whose lines are
  already sampled into this clock domain.
*/
package hcio_pkg;

  // Bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int WADDR_W = 4;
  localparam int BUFSEL_W = 3;
  localparam int CHADDR_W = 12;
  localparam int BUFADDR_W = 15;
  localparam int CSADDR_W = 12;

  // Hard-wired device address on the command bus; the value is arbitrary.
  localparam logic [ADDR_W-1:0] DEV_ADDR = 8'h5A;

  // Control command codes carried in the low byte of the data lines.
  localparam logic [7:0] CC_STATUS = 8'h01;
  localparam logic [7:0] CC_START = 8'h02;
  localparam logic [7:0] CC_STOP = 8'h03;
  localparam logic [7:0] CC_CLR_WADDR = 8'h04;
  localparam logic [7:0] CC_BUFSEL = 8'h05;

  // Field positions inside a buffer-select control word.
  localparam int BUFSEL_A_LSB = 8;
  localparam int BUFSEL_B_LSB = 11;

  // Values after reset.
  localparam logic [WADDR_W-1:0] WADDR_RST = 4'h0;
  localparam logic [BUFSEL_W-1:0] BUFSEL_RST = 3'h0;
  localparam logic [CSADDR_W-1:0] CS_START_ADDR = 12'h000;

  // Status word bit positions.
  localparam int ST_RUN = 0;
  localparam int ST_INT = 1;
  localparam int ST_WADDR_LSB = 4;
  localparam int ST_BUFA_LSB = 8;
  localparam int ST_BUFB_LSB = 11;

  // Command lines of the shared bus: 13 command lines; the 16 data lines are carried separately.
  typedef struct packed {
    logic present;
    logic [ADDR_W-1:0] addr;
    logic is_ctrl;
    logic is_data;
    logic is_input;
    logic cont;
  } hcio_cmd_t;

  // Answer driven back onto the shared bus.
  typedef struct packed {
    logic ack;
    logic reject;
    logic [DATA_W-1:0] data;
    logic data_oe_n;
  } hcio_rsp_t;

  typedef enum logic [1:0] {
    HS_IDLE,
    HS_BUSY
  } hcio_hs_t;

endpackage : hcio_pkg

// ===== hdl/hcio_wstore.sv
/*
  Scratch store of sixteen 16-bit words with one shared address.
  Assumes a write port from the bus side and an asynchronous read.
*/
module hcio_wstore
  import hcio_pkg::*;
(
  input wire logic CLK, // System clock.
  input wire logic CE, // Clock enable.
  input wire logic we, // Write strobe.
  input wire logic [hcio_pkg::WADDR_W-1:0] addr, // Word address.
  input wire logic [hcio_pkg::DATA_W-1:0] wdata, // Write data.
  output logic [hcio_pkg::DATA_W-1:0] rdata // Read data.
);

  logic [DATA_W-1:0] mem [0:(1<<WADDR_W)-1];

  // The store holds no reset; software loads it before use.
  always_ff @(posedge CLK) begin
    if (CE && we) begin
      mem[addr] <= wdata;
    end
  end

  assign rdata = mem[addr];

endmodule : hcio_wstore

// ===== tb/hcio_host.sv
/*
  Host model on the shared command bus: issues one command per call.
  Assumes the device answers with ack or reject while present stands.
*/
module hcio_host
  import hcio_pkg::*;
(
  input wire logic CLK, // System clock.
  output hcio_pkg::hcio_cmd_t CMD, // Command lines driven.
  output logic [hcio_pkg::DATA_W-1:0] BUS_DATA_IN, // Data lines driven.
  input wire hcio_pkg::hcio_rsp_t RSP // Answer seen.
);
  timeunit 1ns;
  timeprecision 1ps;

  // The bus is idle before the first command.
  initial begin
    CMD = '0;
    BUS_DATA_IN = 16'h0000;
  end

  // Present stands until an answer shows or four cycles pass; the host may skip a status read first.
  // Released data lines show the inverse, so a stale value is never mistaken.
  task automatic send(input logic [7:0] a, input logic [3:0] t, input logic [15:0] d,
                      output hcio_rsp_t r, output bit seen);
    seen = 0;
    @(negedge CLK);
    CMD = {1'b1, a, t};
    BUS_DATA_IN = d;
    for (int n = 0; n < 4 && !seen; n++) begin
      @(negedge CLK);
      r = RSP;
      seen = r.ack | r.reject;
    end
    CMD.present = 1'b0;
    BUS_DATA_IN = ~d;
    @(negedge CLK);
  endtask : send
endmodule : hcio_host

// ===== tb/hcio_top_bench.sv
/*
  Self-checking bench for the command interpreter, with a reference model.
  Assumes the host model file is compiled before this one.
*/
module hcio_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import hcio_pkg::*;
  logic CLK, RST_N, CE, UI_VALID, UI_INT_REQ, INTERRUPT, UNIT_CLK_EN;
  logic [11:0] SEQ_NEXT_ADDR, CHA_ADDR, CHB_ADDR, CS_ADDR;
  logic [15:0] BUS_DATA_IN, STATUS;
  logic [14:0] BUF_ADDR_A, BUF_ADDR_B;
  logic [3:0] WADDR;
  hcio_cmd_t CMD;
  hcio_rsp_t RSP;
  int miscompares = 0;
  int total_checks = 0;
  int running, intr, waddr, bufa, bufb, csa;
  int store[16];

  hcio_top dut (.CLK(CLK), .RST_N(RST_N), .CE(CE), .CMD(CMD), .BUS_DATA_IN(BUS_DATA_IN),
    .RSP(RSP), .INTERRUPT(INTERRUPT), .UI_VALID(UI_VALID), .UI_INT_REQ(UI_INT_REQ),
    .SEQ_NEXT_ADDR(SEQ_NEXT_ADDR), .CS_ADDR(CS_ADDR), .UNIT_CLK_EN(UNIT_CLK_EN),
    .CHA_ADDR(CHA_ADDR), .CHB_ADDR(CHB_ADDR), .BUF_ADDR_A(BUF_ADDR_A),
    .BUF_ADDR_B(BUF_ADDR_B), .WADDR(WADDR), .STATUS(STATUS));
  hcio_host host (.CLK(CLK), .CMD(CMD), .BUS_DATA_IN(BUS_DATA_IN), .RSP(RSP));

  // Free-running 20 MHz clock.
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  function automatic logic [15:0] exp_status();
    return {2'b00, 3'(bufb), 3'(bufa), 4'(waddr), 2'b00, 1'(intr), 1'(running)};
  endfunction : exp_status

  // One command through the host; t is {ctrl, data, input, continue}.
  task automatic cmd(input logic [3:0] t, input logic [15:0] d, input logic [7:0] a = DEV_ADDR);
    hcio_rsp_t r;
    bit seen;
    bit ok;
    logic [15:0] rd;
    ok = !running || (t[3] && (t[1] || d[7:0] == CC_STOP));
    rd = t[3] ? exp_status() : 16'(store[waddr]);
    host.send(a, t, d, r, seen);
    if (a != DEV_ADDR) begin
      check("foreign answer", 32'(seen), 0);
      return;
    end
    if (!seen) begin
      miscompares++;
      close_out();
    end
    check("ack", r.ack, ok);
    check("reject", r.reject, !ok);
    check("data drive", r.data_oe_n, !(ok && t[1]));
    if (ok && t[1])
      check("read data", r.data, rd);
    if (ok) begin
      intr = 0;
      if (t[2] && !t[1])
        store[waddr] = d;
      if (t[2] && t[0])
        waddr = (waddr + 1) % 16;
      if (t[3] && !t[1]) begin
        case (d[7:0])
          CC_START: begin
            running = 1;
            csa = 0;
          end
          CC_STOP: running = 0;
          CC_CLR_WADDR: waddr = 0;
          CC_BUFSEL: begin
            bufa = d[10:8];
            bufb = d[13:11];
          end
          default: ;
        endcase
      end
    end
    check("answer released", {RSP.ack, RSP.reject, RSP.data_oe_n}, 3'b001);
    check("status", STATUS, exp_status());
    check("scratch address", WADDR, waddr);
    check("unit clocks", UNIT_CLK_EN, running);
    check("buffer a", BUF_ADDR_A, {3'(bufa), CHA_ADDR});
    check("buffer b", BUF_ADDR_B, {3'(bufb), CHB_ADDR});
    if (ok && t == 4'b1000 && d[7:0] == CC_START)
      check("start address", CS_ADDR, 0);
  endtask : cmd

  // One completing microinstruction, with or without its interrupt bit.
  task automatic micro(input logic irq, input logic [11:0] nxt);
    @(negedge CLK);
    UI_VALID = 1'b1;
    UI_INT_REQ = irq;
    SEQ_NEXT_ADDR = nxt;
    @(negedge CLK);
    UI_VALID = 1'b0;
    if (running)
      csa = nxt;
    check("next address", CS_ADDR, csa);
    if (irq) begin
      running = 0;
      intr = 1;
    end
    check("interrupt", INTERRUPT, intr);
    check("unit clocks", UNIT_CLK_EN, running);
  endtask : micro

  // A hang is cut short here and reported as a failure.
  initial begin
    #2000000;
    miscompares++;
    close_out();
  end

  // Main sequence.
  initial begin
    {RST_N, UI_VALID, UI_INT_REQ, SEQ_NEXT_ADDR, CHA_ADDR, CHB_ADDR} = '0;
    {running, intr, waddr, bufa, bufb, csa} = '0;
    CE = 1'b1;
    void'($urandom(6942));
    repeat (3) @(negedge CLK);
    check("reset outputs", {INTERRUPT, STATUS, RSP.data_oe_n}, 18'h0_0001);
    RST_N = 1'b1;
    CHA_ADDR = 12'($urandom);
    CHB_ADDR = 12'($urandom);
    cmd(4'b1000, {8'h00, CC_CLR_WADDR}, 8'hA5);
    for (int i = 0; i < 18; i++)
      cmd({3'b010, 1'(i != 17)}, 16'($urandom));
    cmd(4'b1000, {8'h00, CC_CLR_WADDR});
    for (int i = 0; i < 16; i++)
      cmd(4'b0111, 16'h0000);
    cmd(4'b1000, {2'b00, 6'($urandom), CC_BUFSEL});
    cmd(4'b1010, 16'h0000);
    cmd(4'b1000, 16'h007E);
    cmd(4'b1000, {8'h00, CC_START});
    cmd(4'b0101, 16'($urandom));
    cmd(4'b0111, 16'h0000);
    cmd(4'b1000, {8'h00, CC_CLR_WADDR});
    cmd(4'b1010, 16'h0000);
    micro(1'b0, 12'($urandom));
    micro(1'b1, 12'($urandom));
    repeat (6) @(negedge CLK);
    check("interrupt held", {INTERRUPT, UNIT_CLK_EN}, 2'b10);
    cmd(4'b1010, 16'h0000);
    cmd(4'b1000, {8'h00, CC_START});
    micro(1'b0, 12'($urandom));
    // Clock enable low must freeze the unit even with a halt request pending.
    @(negedge CLK);
    CE = 1'b0;
    UI_VALID = 1'b1;
    UI_INT_REQ = 1'b1;
    SEQ_NEXT_ADDR = 12'(~csa);
    @(negedge CLK);
    check("frozen address", CS_ADDR, csa);
    check("frozen unit", {INTERRUPT, UNIT_CLK_EN}, 2'b00);
    CE = 1'b1;
    UI_VALID = 1'b0;
    @(negedge CLK);
    check("unit clocks", UNIT_CLK_EN, running);
    cmd(4'b1000, {8'h00, CC_STOP});
    close_out();
  end
endmodule : hcio_top_bench
